// ---- tb/flash_model.sv ----
// behavioural flash device answering command and status cycles
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter int N = 3,
  parameter int TMO = 400
) (
  // pins from the host, and the fault switch from the bench
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_sel_n,
  input wire logic i_fail,
  // pins to the host
  output logic [15:0] o_dq,
  output logic o_rb_n,
  // seen by the bench
  output logic [22:0] o_last,
  output logic [7:0] o_cmd
);
  // ****************************
  // state and status word
  // ****************************
  logic busy = 0, er = 0, lim = 0, t6 = 0, t2 = 0, d7 = 0, pg = 0;
  logic [15:0] last = '0;
  int left = 0;
  time t_er = 0;
  // window closes once the time-out since the last sector erase word ran out
  logic win = 0;
  always #1 win = er && ($time - t_er >= TMO);
  wire rd = !i_oe_n && !i_sel_n;
  wire [15:0] st = {8'h00, ~d7, t6, lim, 1'b0, win, t2, 2'b00};
  // idle bus shows the inverse of the last word, idle banks give data
  assign o_dq = !rd ? ~last : busy ? st : 16'h1234;
  assign o_rb_n = !busy;
  // command words latch on the rising write strobe
  always @(posedge i_we_n)
    if (!i_sel_n && !(busy && win && i_dq[7:0] != 8'hB0))
    begin
      o_cmd = i_dq[7:0];
      if (pg || o_cmd == 8'h30 || o_cmd == 8'h10)
      begin
        busy = 1;
        left = N;
        d7 = pg ? i_dq[7] : 1'b1;
        er = !pg;
      end
      if (!pg && o_cmd == 8'h30)
        t_er = $time;
      if (o_cmd == 8'hF0)
        {busy, er, lim} = '0;
      pg = (o_cmd == 8'hA0);
    end
  // keep the word shown so the released bus can invert it
  always @(negedge (i_oe_n | i_sel_n))
    #1 last = o_dq;
  // each finished read moves the operation toggle bit while busy, and the sector toggle bit only during an erase
  always @(posedge (i_oe_n | i_sel_n))
  begin
    o_last = i_addr;
    if (busy)
    begin
      t6 = !t6;
      t2 = t2 ^ er;
      left = left - 1;
      if (left <= 0 && i_fail)
        lim = 1;
      else if (left <= 0)
        {busy, er} = '0;
    end
  end
endmodule
`default_nettype wire

// ---- tb/flash_status_host_monitor.sv ----
// assertion checker for the flash host's pin cycles
`timescale 1ns/1ps
`default_nettype none
module flash_status_host_monitor (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // flash pins
  input wire logic [22:0] o_addr,
  input wire logic [15:0] o_dq,
  input wire logic o_dq_oe,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic o_flash_select_n
);
  // ****************************
  // pin cycle properties
  // ****************************
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // a read cycle: select and output strobe both low
  wire rd_on = !o_oe_n && !o_flash_select_n;
  a_strobe_excl: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and output strobes low together");
  a_write_drives: assert property (!o_we_n |-> o_dq_oe && !o_flash_select_n)
    else $error("write pulse without driven data");
  a_read_free: assert property (!o_oe_n |-> !o_dq_oe)
    else $error("data driven during read");
  a_addr_held: assert property (rd_on && $past(rd_on) |-> $stable(o_addr))
    else $error("address moved in read");
  a_data_held: assert property (!o_we_n && $past(!o_we_n) |-> $stable(o_dq))
    else $error("data moved in write pulse");
  a_pulse_len: assert property ($fell(o_we_n) |-> !o_we_n [*8])
    else $error("write pulse too short");
  a_setup_done: assert property ($fell(o_we_n) |-> $past(o_dq_oe, 2))
    else $error("write data not set up");
  a_select_len: assert property ($fell(o_flash_select_n) |-> !o_flash_select_n [*3])
    else $error("select pulse too short");
  // reset must idle the pins even though it disables the others
  a_reset_idle: assert property (disable iff (1'b0) !i_nrst |=> o_we_n && !o_dq_oe)
    else $error("pins busy after reset");
  c_write: cover property ($fell(o_we_n));
  c_read: cover property ($fell(o_oe_n) && !o_flash_select_n);
  c_pace: cover property (!o_oe_n && $fell(o_flash_select_n));
endmodule
bind flash_status_host flash_status_host_monitor i_flash_status_host_monitor (.i_core_clk,
  .i_nrst, .o_addr, .o_dq, .o_dq_oe, .o_we_n, .o_oe_n, .o_flash_select_n);
`default_nettype wire

// ---- tb/flash_status_host_tb.sv ----
// testbench for the flash status-polling host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"
module flash_status_host_tb;
  import flash_host_pkg::*;
  // ****************************
  // clock, wires and counters
  // ****************************
  logic i_core_clk = 0, i_nrst = 0, i_reg_wr = 0, i_reg_rd = 0, fail = 0, clk_en = 1;
  logic [7:0] i_reg_addr = '0, cmd;
  logic [31:0] i_reg_wdata = '0, o_reg_rdata, d;
  logic [22:0] o_addr, last_addr;
  logic [15:0] i_dq, o_dq;
  logic o_dq_oe, o_we_n, o_oe_n, o_flash_select_n, i_ready_busy_n;
  int num_errors = 0, checks = 0;
  always #2 i_core_clk = ~i_core_clk;
  flash_status_host i_flash_status_host (.i_core_clk, .i_nrst, .i_clk_en(clk_en),
    .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_addr, .i_dq,
    .o_dq, .o_dq_oe, .o_we_n, .o_oe_n, .o_flash_select_n, .i_ready_busy_n);
  flash_model i_flash_model (.i_addr(o_addr), .i_dq(o_dq), .i_we_n(o_we_n),
    .i_oe_n(o_oe_n), .i_sel_n(o_flash_select_n), .i_fail(fail), .o_dq(i_dq),
    .o_rb_n(i_ready_busy_n), .o_last(last_addr), .o_cmd(cmd));
  // ****************************
  // shared tasks and scenarios
  // ****************************
  task automatic chk(input logic c, input string m);
    checks++;
    if (c !== 1'b1)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= v;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  // order one operation and poll for done, bounded
  task automatic run(input op_t op, input logic [1:0] p);
    wr(`REG_ADDR, 32'h0001_2340);
    wr(`REG_WDATA, 32'h0000_00A5);
    wr(`REG_CTRL, {26'h0, p, op, 1'b1});
    for (int i = 0; i < 3000; i++)
    begin
      rd(`REG_STATUS);
      if (d[1] === 1'b1)
        return;
    end
    chk(1'b0, "operation timed out");
    end_of_test();
  endtask
  task automatic t_prog();
    run(OP_PROGRAM, 2'b00);
    chk(d[2:1] === 2'b01, "program not clean");
    chk(d[3] === 1'b0, "toggle at final look");
    chk(last_addr === 23'h01_2340, "status read elsewhere");
    chk(d[6] === 1'b1, "not ready after program");
    $display("program test over");
  endtask
  task automatic t_fail();
    fail = 1'b1;
    run(OP_PROGRAM, 2'b00);
    chk(d[2:1] === 2'b11, "fault not reported");
    chk(d[3] === 1'b1, "fault without toggle");
    chk(cmd === 8'hF0, "no reset word");
    fail = 1'b0;
    $display("fault test over");
  endtask
  task automatic t_erase();
    run(OP_SECTOR_ERASE, 2'b10);
    chk(d[9] === 1'b1 && d[4:3] === 2'b11, "sector toggle unseen");
    run(OP_POLL, 2'b00);
    chk(d[2:1] === 2'b01, "resumed poll not clean");
    run(OP_ADD_SECTOR, 2'b00);
    chk(d[8:7] === 2'b00, "extra erase refused");
    run(OP_CHIP_ERASE, 2'b00);
    chk(d[2:1] === 2'b01, "chip erase not clean");
    run(OP_SUSPEND, 2'b00);
    chk(cmd === 8'hB0, "no suspend word");
    $display("erase test over");
  endtask
  task automatic t_pace();
    run(OP_READ, 2'b01);
    rd(`REG_RDATA);
    chk(d[15:0] === 16'h1234, "paced read wrong");
    rd(8'h20);
    chk(d === 32'h0000_0000, "unmapped read not zero");
    @(posedge i_core_clk);
    clk_en <= 1'b0;
    wr(`REG_CTRL, 32'h0000_000F);
    clk_en <= 1'b1;
    rd(`REG_CTRL);
    chk(d === 32'h0000_001E, "frozen write stored");
    $display("paced read test over");
  endtask
  initial
  begin
    repeat (12) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    t_prog();
    t_fail();
    t_erase();
    t_pace();
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- verilog/flash_bus_cycle.sv ----
// one asynchronous write or read cycle on the flash pins
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"

module flash_bus_cycle
(
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic i_pace_sel,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_wdata,
  output logic o_done,
  output logic [15:0] o_rdata,
  // flash pins
  output logic [22:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_flash_select_n
);

  // ***********************************************
  // timing counts, least times rounded up
  // ***********************************************
  localparam int SETUP_CYC = (`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int PULSE_CYC = (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HOLD_CYC = (`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int TOTAL_CYC = SETUP_CYC + PULSE_CYC + HOLD_CYC;

  logic active_reg; // a cycle is running
  logic write_reg; // running cycle is a write
  logic pace_reg; // select paces reads
  logic [7:0] cnt_reg; // cycle position
  logic [15:0] rdata_reg; // captured read word
  logic [22:0] addr_reg; // held address
  logic [15:0] wdata_reg; // held write word

  wire in_pulse = active_reg && (cnt_reg >= 8'(SETUP_CYC))
    && (cnt_reg < 8'(SETUP_CYC + PULSE_CYC));
  wire last_pulse = active_reg && (cnt_reg == 8'(SETUP_CYC + PULSE_CYC - 1));
  wire last_cyc = active_reg && (cnt_reg == 8'(TOTAL_CYC - 1));

  // ***********************************************
  // cycle sequencer
  // ***********************************************
  // address and data are held for the whole cycle so the strobe edges
  // never meet a moving bus
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      active_reg <= 1'b0;
      write_reg <= 1'b0;
      pace_reg <= 1'b0;
      cnt_reg <= 8'h00;
      rdata_reg <= 16'h0000;
      addr_reg <= 23'h00_0000;
      wdata_reg <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      if (!active_reg && i_start)
      begin
        active_reg <= 1'b1;
        write_reg <= i_write;
        pace_reg <= i_pace_sel;
        addr_reg <= i_addr;
        wdata_reg <= i_wdata;
        cnt_reg <= 8'h00;
      end
      else if (active_reg)
      begin
        cnt_reg <= cnt_reg + 8'h01;
        if (last_pulse && !write_reg)
          rdata_reg <= i_dq; // sample at the end of the strobe
        if (last_cyc)
          active_reg <= 1'b0;
      end
    end
  end

  // ***********************************************
  // pin drive
  // ***********************************************
  // a write is latched by the device on the rising edge of the write strobe
  assign o_addr = addr_reg;
  assign o_dq = wdata_reg;
  assign o_dq_oe = active_reg && write_reg;
  assign o_we_n = !(in_pulse && write_reg);
  // reads paced by the output strobe or by the chip select
  assign o_oe_n = !(!write_reg && (pace_reg ? active_reg : in_pulse));
  // a write keeps the select low around its strobe, paced or not
  assign o_flash_select_n = !((pace_reg && !write_reg) ? in_pulse : active_reg);
  assign o_done = last_cyc && i_clk_en;
  assign o_rdata = rdata_reg;

endmodule
`default_nettype wire

// ---- verilog/flash_host_params.svh ----
// constants for the flash status-polling host controller
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH

// ***********************************************
// software register offsets (byte addresses)
// ***********************************************
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10

// ***********************************************
// control register fields
// ***********************************************
`define CTRL_GO 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 3
`define CTRL_PACE_SEL 4
`define CTRL_ABORT 5
`define CTRL_RESET_VAL 32'h0000_0000

// ***********************************************
// status register fields
// ***********************************************
`define ST_BUSY 0
`define ST_DONE 1
`define ST_FAIL 2
`define ST_OP_TOGGLE 3
`define ST_SEC_TOGGLE 4
`define ST_WINDOW 5
`define ST_READY 6
`define ST_NOT_ACCEPTED 7
`define ST_REFUSED 8
`define ST_ABORTED 9

// ***********************************************
// status bit positions in the low status byte
// ***********************************************
`define BIT_SEC_TOGGLE 2
`define BIT_WINDOW 3
`define BIT_TIMING_LIMIT 5
`define BIT_OP_TOGGLE 6
`define BIT_DATA_POLL 7

// ***********************************************
// command words (unlock addresses and codes)
// ***********************************************
`define UNLOCK_ADDR1 23'h00_0555
`define UNLOCK_ADDR2 23'h00_02AA
`define CODE_UNLOCK1 16'h00AA
`define CODE_UNLOCK2 16'h0055
`define CODE_PROGRAM 16'h00A0
`define CODE_ERASE_SETUP 16'h0080
`define CODE_SECTOR_ERASE 16'h0030
`define CODE_CHIP_ERASE 16'h0010
`define CODE_SUSPEND 16'h00B0
`define CODE_RESET 16'h00F0

// ***********************************************
// pin timing, in ns, and clock period
// ***********************************************
`define CLK_PERIOD_NS 4
`define T_SETUP_NS 10
`define T_PULSE_NS 70
`define T_HOLD_NS 20

`endif

// ---- verilog/flash_host_pkg.sv ----
// types for the flash status-polling host controller
package flash_host_pkg;

  // operations that software can order
  typedef enum logic [2:0] {
    OP_PROGRAM = 3'h0,
    OP_SECTOR_ERASE = 3'h1,
    OP_ADD_SECTOR = 3'h2,
    OP_CHIP_ERASE = 3'h3,
    OP_SUSPEND = 3'h4,
    OP_RESET = 3'h5,
    OP_POLL = 3'h6,
    OP_READ = 3'h7
  } op_t;

  // controller states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_SEQ = 8'h02,
    S_PRE = 8'h04,
    S_POST = 8'h08,
    S_RD = 8'h10,
    S_JUDGE = 8'h20,
    S_RESET = 8'h40,
    S_ARRAY = 8'h80
  } state_t;

endpackage

// ---- verilog/flash_host_regs.sv ----
// software register file of the flash status-polling host controller
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"

module flash_host_regs
(
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // software port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // fields to the controller
  output logic o_go,
  output logic [2:0] o_op,
  output logic o_pace_sel,
  output logic o_abort,
  output logic [22:0] o_addr,
  output logic [15:0] o_wdata,
  // state from the controller
  input wire logic [9:0] i_status,
  input wire logic [15:0] i_last_word
);

  logic [31:0] ctrl_reg; // operation, pacing and abort bits kept
  logic [22:0] addr_reg; // target address
  logic [15:0] wdata_reg; // program datum
  logic [31:0] rdata_reg; // read answer
  logic [31:0] rdata_next;

  wire wr_ctrl = i_reg_wr && (i_reg_addr == `REG_CTRL);

  // ***********************************************
  // read decode, unmapped reads as zero
  // ***********************************************
  always_comb
  begin
    case (i_reg_addr)
      `REG_CTRL: rdata_next = ctrl_reg;
      `REG_ADDR: rdata_next = {9'h000, addr_reg};
      `REG_WDATA: rdata_next = {16'h0000, wdata_reg};
      `REG_STATUS: rdata_next = {22'h00_0000, i_status};
      `REG_RDATA: rdata_next = {16'h0000, i_last_word};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // ***********************************************
  // register storage
  // ***********************************************
  // the go bit is not stored: it is a one-cycle order
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      ctrl_reg <= `CTRL_RESET_VAL;
      addr_reg <= 23'h00_0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 32'h0000_0000;
    end
    else if (i_clk_en)
    begin
      if (wr_ctrl)
        ctrl_reg <= i_reg_wdata & 32'h0000_003E;
      if (i_reg_wr && (i_reg_addr == `REG_ADDR))
        addr_reg <= i_reg_wdata[22:0];
      if (i_reg_wr && (i_reg_addr == `REG_WDATA))
        wdata_reg <= i_reg_wdata[15:0];
      if (i_reg_rd)
        rdata_reg <= rdata_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_go = wr_ctrl && i_reg_wdata[`CTRL_GO] && i_clk_en;
  assign o_op = wr_ctrl ? i_reg_wdata[`CTRL_OP_HI:`CTRL_OP_LO]
    : ctrl_reg[`CTRL_OP_HI:`CTRL_OP_LO];
  assign o_pace_sel = ctrl_reg[`CTRL_PACE_SEL];
  assign o_abort = ctrl_reg[`CTRL_ABORT];
  assign o_addr = addr_reg;
  assign o_wdata = wdata_reg;

endmodule
`default_nettype wire

// ---- verilog/flash_status_host.sv ----
// host controller that issues flash commands and polls write status
//
// Behaviour
// - reads paced by output strobe or select
// - start check with two back-to-back reads
// - no toggle means finished, array readable
// - toggling with limit flag: recheck, reset
// - resumed monitoring restarts the whole check
// - reset command after limit fault
// - check window flag around extra erases
// - status reads use the busy address
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_params.svh"

module flash_status_host
(
  // clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_clk_en,
  // software register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // flash pins
  output logic [22:0] o_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic o_dq_oe,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_flash_select_n,
  input wire logic i_ready_busy_n
);
  import flash_host_pkg::*;

  // ***********************************************
  // declarations
  // ***********************************************
  state_t state_reg; // controller state
  state_t state_next;
  op_t op_reg; // operation in progress
  logic [2:0] step_reg; // command word index
  logic [1:0] rd_cnt_reg; // status reads since the check began, held at one
  logic recheck_reg; // second look after the limit flag rose
  logic [15:0] prev_reg; // earlier status word
  logic [15:0] cur_reg; // latest status word
  logic done_reg; // operation finished
  logic fail_reg; // operation failed
  logic op_tog_reg; // operation bit toggled at the last judgement
  logic sec_tog_reg; // sector bit toggled at the last judgement
  logic window_reg; // window flag from the last status read
  logic not_acc_reg; // extra sector erase may have been lost
  logic refused_reg; // extra sector erase refused, window closed
  logic aborted_reg; // polling left to software
  logic ready_reg; // sampled ready/busy level

  // register file fields
  logic go;
  logic [2:0] op_in;
  logic pace_sel;
  logic abort;
  logic [22:0] tgt_addr;
  logic [15:0] tgt_data;
  logic [9:0] status;

  // bus cycle engine
  logic cyc_start;
  logic cyc_write;
  logic [22:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  // ***********************************************
  // command tables
  // ***********************************************
  // number of write cycles of each command
  function automatic logic [2:0] seq_len(input op_t op);
    case (op)
      OP_PROGRAM: seq_len = 3'd4;
      OP_SECTOR_ERASE: seq_len = 3'd6;
      OP_CHIP_ERASE: seq_len = 3'd6;
      default: seq_len = 3'd1;
    endcase
  endfunction

  // address and datum of one command word; the last word of every command but
  // chip erase goes to the target, where the status that follows is read too
  function automatic logic [38:0] seq_word(input op_t op, input logic [2:0] step,
    input logic [22:0] addr, input logic [15:0] data);
    logic [38:0] w;
    w = {addr, data};
    case (step)
      3'd0: if (op != OP_ADD_SECTOR && op != OP_SUSPEND && op != OP_RESET)
        w = {`UNLOCK_ADDR1, `CODE_UNLOCK1};
      3'd1: w = {`UNLOCK_ADDR2, `CODE_UNLOCK2};
      3'd2: w = {`UNLOCK_ADDR1, (op == OP_PROGRAM) ? `CODE_PROGRAM : `CODE_ERASE_SETUP};
      3'd3: w = (op == OP_PROGRAM) ? {addr, data} : {`UNLOCK_ADDR1, `CODE_UNLOCK1};
      3'd4: w = {`UNLOCK_ADDR2, `CODE_UNLOCK2};
      default: w = {addr, data};
    endcase
    if (step == seq_len(op) - 3'd1)
    begin
      case (op)
        OP_SECTOR_ERASE: w = {addr, `CODE_SECTOR_ERASE};
        OP_ADD_SECTOR: w = {addr, `CODE_SECTOR_ERASE};
        OP_CHIP_ERASE: w = {`UNLOCK_ADDR1, `CODE_CHIP_ERASE};
        OP_SUSPEND: w = {addr, `CODE_SUSPEND};
        OP_RESET: w = {addr, `CODE_RESET};
        default: w = {addr, data};
      endcase
    end
    seq_word = w;
  endfunction

  // ***********************************************
  // decode of the status pair
  // ***********************************************
  wire last_step = (step_reg == seq_len(op_reg) - 3'd1);
  wire [38:0] word_now = seq_word(op_reg, step_reg, tgt_addr, tgt_data);
  wire op_toggled = prev_reg[`BIT_OP_TOGGLE] ^ cur_reg[`BIT_OP_TOGGLE];
  wire sec_toggled = prev_reg[`BIT_SEC_TOGGLE] ^ cur_reg[`BIT_SEC_TOGGLE];
  wire limit_high = cur_reg[`BIT_TIMING_LIMIT];
  wire rd_window = cyc_rdata[`BIT_WINDOW];
  wire in_write = (state_reg == S_SEQ) || (state_reg == S_RESET);
  wire busy = (state_reg != S_IDLE);

  // ***********************************************
  // submodules
  // ***********************************************
  flash_host_regs u_regs
  (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_go(go),
    .o_op(op_in),
    .o_pace_sel(pace_sel),
    .o_abort(abort),
    .o_addr(tgt_addr),
    .o_wdata(tgt_data),
    .i_status(status),
    .i_last_word(cur_reg)
  );

  // every status read goes to the target address, inside the busy bank
  assign cyc_write = in_write;
  assign cyc_addr = (state_reg == S_SEQ) ? word_now[38:16] : tgt_addr;
  assign cyc_wdata = (state_reg == S_SEQ) ? word_now[15:0] : `CODE_RESET;
  assign cyc_start = busy && (state_reg != S_JUDGE);

  flash_bus_cycle u_cycle
  (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_clk_en(i_clk_en),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_pace_sel(pace_sel),
    .i_addr(cyc_addr),
    .i_wdata(cyc_wdata),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr(o_addr),
    .i_dq(i_dq),
    .o_dq(o_dq),
    .o_dq_oe(o_dq_oe),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n),
    .o_flash_select_n(o_flash_select_n)
  );

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
      begin
        if (go)
        begin
          case (op_t'(op_in))
            OP_ADD_SECTOR: state_next = S_PRE; // look at the window first
            OP_POLL: state_next = S_RD; // monitoring always restarts here
            OP_READ: state_next = S_ARRAY;
            default: state_next = S_SEQ;
          endcase
        end
      end
      S_PRE:
      begin
        // window already closed: the device would drop the command
        if (cyc_done)
          state_next = rd_window ? S_IDLE : S_SEQ;
      end
      S_SEQ:
      begin
        // status is valid once the last write strobe has risen
        if (cyc_done && last_step)
        begin
          if (op_reg == OP_ADD_SECTOR)
            state_next = S_POST;
          else if (op_reg == OP_SUSPEND || op_reg == OP_RESET)
            state_next = S_IDLE;
          else
            state_next = S_RD;
        end
      end
      S_POST:
        if (cyc_done)
          state_next = S_RD;
      S_RD:
        if (cyc_done && rd_cnt_reg == 2'd1)
          state_next = S_JUDGE; // two reads in a row before the first verdict, one more read before each later one
      S_JUDGE:
      begin
        if (!op_toggled)
          state_next = S_IDLE; // finished
        else if (recheck_reg)
          state_next = S_RESET; // still toggling after the limit flag
        else if (!limit_high && abort)
          state_next = S_IDLE;
        else
          state_next = S_RD;
      end
      S_RESET:
        if (cyc_done)
          state_next = S_IDLE; // reset command, then back to idle
      S_ARRAY:
        if (cyc_done)
          state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ***********************************************
  // state and step registers
  // ***********************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state_reg <= S_IDLE;
      op_reg <= OP_PROGRAM;
      step_reg <= 3'd0;
    end
    else if (i_clk_en)
    begin
      state_reg <= state_next;
      if (state_reg == S_IDLE && go)
      begin
        op_reg <= op_t'(op_in);
        step_reg <= 3'd0;
      end
      else if (state_reg == S_SEQ && cyc_done)
        step_reg <= step_reg + 3'd1;
    end
  end

  // ***********************************************
  // status word capture and toggle judgement
  // ***********************************************
  // a continued watch compares each new read with the one before it, so a
  // second look after the limit flag costs just one more read
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      rd_cnt_reg <= 2'd0;
      recheck_reg <= 1'b0;
      prev_reg <= 16'h0000;
      cur_reg <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      if (state_reg == S_IDLE)
      begin
        rd_cnt_reg <= 2'd0; // every new check starts from the first read
        recheck_reg <= 1'b0;
      end
      else if (cyc_done && state_reg != S_SEQ && state_reg != S_RESET)
      begin
        prev_reg <= cur_reg;
        cur_reg <= cyc_rdata;
        if (state_reg == S_RD)
          rd_cnt_reg <= 2'd1;
      end
      else if (state_reg == S_JUDGE && op_toggled && limit_high)
        recheck_reg <= 1'b1; // the bit may have stopped as the flag rose
    end
  end

  // ***********************************************
  // status flags
  // ***********************************************
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      op_tog_reg <= 1'b0;
      sec_tog_reg <= 1'b0;
      window_reg <= 1'b0;
      not_acc_reg <= 1'b0;
      refused_reg <= 1'b0;
      aborted_reg <= 1'b0;
      ready_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      ready_reg <= i_ready_busy_n;
      if (state_reg == S_IDLE && go)
      begin
        // a new order clears the previous outcome
        done_reg <= 1'b0;
        fail_reg <= 1'b0;
        not_acc_reg <= 1'b0;
        refused_reg <= 1'b0;
        aborted_reg <= 1'b0;
      end
      else if (state_next == S_IDLE && state_reg != S_IDLE)
        done_reg <= 1'b1;
      if ((state_reg == S_PRE || state_reg == S_POST) && cyc_done)
        window_reg <= rd_window;
      if (state_reg == S_PRE && cyc_done && rd_window)
        refused_reg <= 1'b1;
      if (state_reg == S_POST && cyc_done && rd_window)
        not_acc_reg <= 1'b1;
      if (state_reg == S_JUDGE)
      begin
        op_tog_reg <= op_toggled;
        sec_tog_reg <= sec_toggled;
        window_reg <= cur_reg[`BIT_WINDOW];
        if (op_toggled && recheck_reg)
          fail_reg <= 1'b1;
        if (op_toggled && !recheck_reg && !limit_high && abort)
          aborted_reg <= 1'b1;
      end
    end
  end

  // ***********************************************
  // status word
  // ***********************************************
  assign status = {aborted_reg, refused_reg, not_acc_reg, ready_reg, window_reg,
    sec_tog_reg, op_tog_reg, fail_reg, done_reg, busy};

endmodule
`default_nettype wire
